// file: core/dma_request_mask_set.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module dma_request_mask_set
   import req_mask_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Variant strap
   input  wire logic              first_converter_fitted,
   // Write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // Write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // Read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Peripheral requests
   input  wire logic [CHAN_N-1:0] periph_req,
   output logic      [CHAN_N-1:0] arb_req,
   output logic      [CHAN_N-1:0] mask_out
);
   function automatic logic [15:0] lane_mask(input logic [31:0] d, input logic [3:0] s);
      lane_mask = {d[15:8] & {8{s[1]}}, d[7:0] & {8{s[0]}}};
   endfunction : lane_mask

   ////////////////////////////////////////////////////////////////////////////
   // Write channel state
   logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
   logic              aw_have_reg, aw_have_next;
   logic [31:0]       wdata_reg, wdata_next;
   logic [3:0]        wstrb_reg, wstrb_next;
   logic              w_have_reg, w_have_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   logic [15:0]       mask_reg, mask_next;
   logic              do_write;
   logic [15:0]       wbits;

   // Ready drops while a response waits, so at most one write is ever in flight
   assign s_axi_awready = !aw_have_reg && !bvalid_reg;
   assign s_axi_wready  = !w_have_reg && !bvalid_reg;
   assign do_write      = aw_have_reg && w_have_reg && !bvalid_reg;
   assign wbits         = lane_mask(wdata_reg, wstrb_reg);

   always_comb
   begin
      awaddr_next  = awaddr_reg;
      aw_have_next = aw_have_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      w_have_next  = w_have_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      mask_next    = mask_reg;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awaddr_next  = s_axi_awaddr;
         aw_have_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
         w_have_next = 1'b1;
      end
      if (do_write)
      begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = RESP_OKAY;
         // Ones set at the set offset and clear at the clear offset; zeros leave bits alone
         if (awaddr_reg == SET_OFFSET)
            mask_next = mask_reg | wbits;
         else if (awaddr_reg == CLEAR_OFFSET)
            mask_next = mask_reg & ~wbits;
         else
            bresp_next = RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
         bvalid_next = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awaddr_reg  <= '0;
         aw_have_reg <= 1'b0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         w_have_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         mask_reg    <= MASK_RESET;
      end
      else
      begin
         awaddr_reg  <= awaddr_next;
         aw_have_reg <= aw_have_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         w_have_reg  <= w_have_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         mask_reg    <= mask_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read channel; both offsets return the live mask
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;

   // Read data is a snapshot at the address handshake; a write landing then shows next read
   assign s_axi_arready = !rvalid_reg;

   always_comb
   begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_next = 1'b1;
         if (s_axi_araddr == SET_OFFSET || s_axi_araddr == CLEAR_OFFSET)
         begin
            rdata_next = {UPPER_ZERO, mask_reg};
            rresp_next = RESP_OKAY;
         end
         else
         begin
            rdata_next = '0;
            rresp_next = RESP_SLVERR;
         end
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_next = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= RESP_OKAY;
      end
      else
      begin
         rvalid_reg <= rvalid_next;
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;
   assign mask_out     = mask_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Request gating toward the arbiter
   req_gate u_gate
   (
      .mask                   (mask_reg),
      .first_converter_fitted (first_converter_fitted),
      .req_in                 (periph_req),
      .req_out                (arb_req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   set_ones_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      do_write && awaddr_reg == SET_OFFSET |=> ((mask_reg & $past(wbits)) == $past(wbits)))
      else $error("set write did not mask");
   set_zeros_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(do_write && awaddr_reg == CLEAR_OFFSET) |=> ((mask_reg & $past(mask_reg)) == $past(mask_reg)))
      else $error("mask bit dropped without clear write");
   clear_ones_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      do_write && awaddr_reg == CLEAR_OFFSET |=> ((mask_reg & $past(wbits)) == 16'h0000))
      else $error("clear write left mask");
   upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_rvalid |-> s_axi_rdata[31:16] == UPPER_ZERO)
      else $error("upper bits not zero");
   read_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == SET_OFFSET && !do_write
      |=> s_axi_rdata[15:0] == $past(mask_reg))
      else $error("read data not mask");
   gate_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (arb_req & mask_reg) == 16'h0000)
      else $error("masked request passed");
   variant_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !first_converter_fitted |-> !arb_req[FIRST_CONVERTER_CHAN])
      else $error("absent converter requested");
   reset_zero_a: assert property (@(posedge clk_sys)
      $rose(rst_n) |-> mask_reg == MASK_RESET || $past(do_write, 1))
      else $error("mask not zero after reset");
   write_resp_c: cover property (@(posedge clk_sys) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
   read_resp_c: cover property (@(posedge clk_sys) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
   block_c: cover property (@(posedge clk_sys) disable iff (!rst_n) periph_req[0] && mask_reg[0]);
   clear_c: cover property (@(posedge clk_sys) disable iff (!rst_n) do_write && awaddr_reg == CLEAR_OFFSET);
   variant_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      !first_converter_fitted && periph_req[FIRST_CONVERTER_CHAN]);
endmodule : dma_request_mask_set

// file: core/req_mask_pkg.sv
// Notes on behaviour
// - Mask word is 32 bits; upper sixteen read zero and ignore writes.
// - Reading a channel bit gives 1 when masked, 0 when requests allowed.
// - Writing 1 to the set register masks that channel's peripheral requests.
// - Writing 0 to the set register leaves the mask bit as it is.
// - Bits 15 to 0 map to the sixteen named peripheral channels.
// - First converter channel only works on the variant that has that converter.
// - After reset every mask bit is zero.
// - Writing 1 to the clear register unmasks that channel; 0 has no effect.
package req_mask_pkg;
   localparam int          ADDR_W              = 6;
   localparam int          CHAN_N              = 16;
   localparam logic [5:0]  SET_OFFSET          = 6'h20;
   localparam logic [5:0]  CLEAR_OFFSET        = 6'h24;
   localparam logic [15:0] MASK_RESET          = 16'h0000;
   localparam logic [15:0] UPPER_ZERO          = 16'h0000;
   localparam logic [1:0]  RESP_OKAY           = 2'h0;
   localparam logic [1:0]  RESP_SLVERR         = 2'h2;
   // Channel positions
   localparam int          SECOND_UART_RX_CHAN = 15;
   localparam int          SECOND_UART_TX_CHAN = 14;
   localparam int          SPI_PORT_A_RX_CHAN  = 13;
   localparam int          SPI_PORT_A_TX_CHAN  = 12;
   localparam int          SINC_FILTER_CHAN    = 11;
   localparam int          SECOND_CONVERTER_CHAN = 10;
   localparam int          FIRST_CONVERTER_CHAN = 9;
   localparam int          DAC_CHAN            = 8;
   localparam int          I2C_MASTER_RX_CHAN  = 7;
   localparam int          I2C_MASTER_TX_CHAN  = 6;
   localparam int          I2C_SLAVE_RX_CHAN   = 5;
   localparam int          I2C_SLAVE_TX_CHAN   = 4;
   localparam int          FIRST_UART_RX_CHAN  = 3;
   localparam int          FIRST_UART_TX_CHAN  = 2;
   localparam int          SPI_PORT_B_RX_CHAN  = 1;
   localparam int          SPI_PORT_B_TX_CHAN  = 0;
endpackage : req_mask_pkg

// file: core/req_gate.sv
`timescale 1ns/100ps
module req_gate
   import req_mask_pkg::*;
(
   // Mask and requests
   input  wire logic [CHAN_N-1:0] mask,
   input  wire logic              first_converter_fitted,
   input  wire logic [CHAN_N-1:0] req_in,
   // Gated requests
   output logic      [CHAN_N-1:0] req_out
);
   logic [CHAN_N-1:0] present;

   always_comb
   begin
      present                       = '1;
      present[FIRST_CONVERTER_CHAN] = first_converter_fitted;
      req_out                       = req_in & ~mask & present;
   end
endmodule : req_gate

// file: sim/periph_req_model.sv
`timescale 1ns/100ps
module periph_req_model
   import req_mask_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Request lines
   output logic      [CHAN_N-1:0] periph_req
);
   // Peripherals raise requests independently, so every line may change each cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         periph_req <= '0;
      else
         periph_req <= CHAN_N'($urandom);
   end
endmodule : periph_req_model

// file: sim/tb_dma_request_mask_set.sv
`timescale 1ns/100ps
module tb_dma_request_mask_set;
   import req_mask_pkg::*;
   logic        clk_sys, rst_n, fit, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] preq, arb, mask, exp_mask, d, model_mask;
   logic [33:0] note;
   logic [33:0] rq[$];
   logic [33:0] bq[$];
   int          n_errors, total_checks;
   dma_request_mask_set uut(.clk_sys(clk_sys), .rst_n(rst_n), .first_converter_fitted(fit),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .periph_req(preq), .arb_req(arb), .mask_out(mask));
   periph_req_model peer(.clk_sys(clk_sys), .rst_n(rst_n), .periph_req(preq));
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   function automatic logic mapped(input logic [5:0] a);
      return a == SET_OFFSET || a == CLEAR_OFFSET;
   endfunction : mapped
   task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [3:0] s);
      logic ta, tw, tb;
      // Only byte lanes 0 and 1 reach the mask; the upper lanes are reserved
      d = {s[1] ? v[15:8] : 8'h00, s[0] ? v[7:0] : 8'h00};
      if (a == SET_OFFSET)
         exp_mask = exp_mask | d;
      else if (a == CLEAR_OFFSET)
         exp_mask = exp_mask & ~d;
      bq.push_back({16'h0000, mapped(a) ? RESP_OKAY : RESP_SLVERR, exp_mask});
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 50; i++)
      begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         @(posedge clk_sys);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
         begin
            bready <= 1'b0;
            return;
         end
      end
      n_errors++;
      give_verdict;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      logic ta, tr;
      rq.push_back({mapped(a) ? RESP_OKAY : RESP_SLVERR, mapped(a) ? {UPPER_ZERO, exp_mask} : 32'h0});
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 50; i++)
      begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid && rready;
         @(posedge clk_sys);
         if (ta)
            arvalid <= 1'b0;
         if (tr)
         begin
            rready <= 1'b0;
            return;
         end
      end
      n_errors++;
      give_verdict;
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   // The gating reference follows the bench's own expected mask, taken over as each write answers
   always @(negedge clk_sys)
   begin
      if (rst_n !== 1'b1)
         model_mask = MASK_RESET;
      else
      begin
         if (bvalid && bready)
         begin
            note = bq.pop_front();
            check({16'h0000, bresp, mask}, note);
            model_mask = note[15:0];
         end
         check({18'h0, arb}, {18'h0, preq & ~model_mask & {6'h3f, fit, 9'h1ff}});
         if (rvalid && rready)
            check({rresp, rdata}, rq.pop_front());
      end
   end
   initial
   begin
      {fit, rst_n, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
      {awaddr, araddr, wdata, wstrb, exp_mask} = '0;
      n_errors = 0;
      total_checks = 0;
      void'($urandom(66496));
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(SET_OFFSET);
      $display("test reset value done");
      // Upper half written with ones must never stick
      for (int i = 0; i < 16; i++)
      begin
         wr(SET_OFFSET, 32'hffff0000 | (32'h1 << i), 4'hf);
         rd(SET_OFFSET);
      end
      $display("test channel walk done");
      repeat (24)
      begin
         wr($urandom % 2 ? SET_OFFSET : CLEAR_OFFSET, $urandom, 4'($urandom));
         rd(CLEAR_OFFSET);
      end
      $display("test random set and clear done");
      // A reset in mid-run must drop every mask bit again
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      exp_mask = MASK_RESET;
      rd(SET_OFFSET);
      $display("test mid-run reset done");
      wr(6'h10, 32'hffffffff, 4'hf);
      rd(6'h3c);
      rd(SET_OFFSET);
      $display("test unmapped access done");
      fit <= 1'b0;
      wr(CLEAR_OFFSET, 32'h0000ffff, 4'h3);
      repeat (20) @(posedge clk_sys);
      fit <= 1'b1;
      repeat (20) @(posedge clk_sys);
      $display("test variant strap done");
      give_verdict;
   end
endmodule : tb_dma_request_mask_set
